// [rtl/sweep_pkg.sv]
// Shared register map, field layout and timing for the sweep recorder
package sweep_pkg;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_PRE_LEN  = 8'h04;
  localparam logic [7:0]  ADDR_POST_LEN = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_USED     = 8'h10;
  localparam logic [7:0]  ADDR_LAST_PRE = 8'h14;
  localparam logic [7:0]  ADDR_LAST_BTW = 8'h18;
  localparam logic [7:0]  ADDR_LAST_PST = 8'h1c;
  localparam logic [7:0]  ADDR_SWEEPS   = 8'h20;

  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_STREAM_BIT = 1;
  localparam int          CTRL_MODE_LSB   = 2;
  localparam int          CTRL_TSRC_LSB   = 4;
  localparam int          CTRL_SSRC_BIT   = 6;
  localparam int          STAT_SUSP_BIT   = 0;
  localparam int          STAT_EXH_BIT    = 1;
  localparam int          STAT_PHASE_LSB  = 2;

  localparam logic [31:0] PRE_LEN_RST  = 32'h0000_0000;
  localparam logic [31:0] POST_LEN_RST = 32'h0000_0000;
  localparam logic [1:0]  MODE_RST     = 2'h0;

  localparam logic [1:0]  MODE_FIRST = 2'h0;
  localparam logic [1:0]  MODE_EVERY = 2'h1;
  localparam logic [1:0]  MODE_STOP  = 2'h2;

  localparam logic [1:0]  TSRC_EXT     = 2'h0;
  localparam logic [1:0]  TSRC_ANALOG  = 2'h1;
  localparam logic [1:0]  TSRC_DIGITAL = 2'h2;
  localparam logic [1:0]  TSRC_FORMULA = 2'h3;
  localparam logic        SSRC_EXT     = 1'b0;

  localparam logic [1:0]  SEG_PRE    = 2'h0;
  localparam logic [1:0]  SEG_BTW    = 2'h1;
  localparam logic [1:0]  SEG_POST   = 2'h2;
  localparam logic [1:0]  SEG_STREAM = 2'h3;

  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          BTW_MIN_US     = 2500;
  localparam int          BTW_MIN_CYCLES =
    (BTW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [rtl/trig_if.sv]
// Trigger source selection and event pulses between core and selector
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
  logic [1:0] tsrc;
  logic       ssrc;
  logic       trig;
  logic       stop;
  modport sel  (input tsrc, input ssrc, output trig, output stop);
  modport core (output tsrc, output ssrc, input trig, input stop);
endinterface
`default_nettype wire

// [rtl/trig_select.sv]
// Trigger and stop-trigger source selection with rising edge detection
`timescale 1ns/1ps
`default_nettype none
module trig_select (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ext_trig,
  input  wire logic analog_trig,
  input  wire logic digital_trig,
  input  wire logic formula_trig,
  input  wire logic formula_stop,
  trig_if.sel       tif
);
  typedef struct packed {
    logic prev_t;
    logic prev_s;
    logic trig;
    logic stop;
  } sel_state_t;

  sel_state_t q;
  sel_state_t n;
  logic       lvl_t;
  logic       lvl_s;

  always_comb begin
    case (tif.tsrc)
      sweep_pkg::TSRC_EXT:     lvl_t = ext_trig;
      sweep_pkg::TSRC_ANALOG:  lvl_t = analog_trig;
      sweep_pkg::TSRC_DIGITAL: lvl_t = digital_trig;
      default:                 lvl_t = formula_trig;
    endcase
    // Only two stop sources exist
    lvl_s    = (tif.ssrc == sweep_pkg::SSRC_EXT) ? ext_trig : formula_stop;
    n.prev_t = lvl_t;
    n.prev_s = lvl_s;
    n.trig   = lvl_t && !q.prev_t;
    n.stop   = lvl_s && !q.prev_s;
  end

  // A source switch may produce one stray edge; software switches while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tif.trig = q.trig;
  assign tif.stop = q.stop;
endmodule
`default_nettype wire

// [rtl/sweep_recorder.sv]
// Sweep capture controller with APB registers and streaming FIFO control
`timescale 1ns/1ps
`default_nettype none

module sweep_recorder #(
  parameter int unsigned DATA_W      = 16,
  parameter int unsigned MEM_DEPTH   = 32'h0010_0000,
  parameter int unsigned BTW_RESERVE = sweep_pkg::BTW_MIN_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              ext_trig,
  input  wire logic              analog_trig,
  input  wire logic              digital_trig,
  input  wire logic              formula_trig,
  input  wire logic              formula_stop,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic              drain_ack,
  input  wire logic              peer_fifo_empty,
  output logic                   rec_valid,
  output logic [DATA_W-1:0]      rec_data,
  output logic [1:0]             rec_seg,
  output logic                   rec_marker,
  output logic                   sweep_done,
  output logic                   log_valid,
  output logic [31:0]            log_time,
  output logic [1:0]             log_src,
  output logic                   suspended,
  output logic                   mem_exhausted
);
  typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_BTW, PH_POST} phase_t;
  typedef struct packed {
    phase_t            phase;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              en;
    logic              stream;
    logic [1:0]        mode;
    logic [1:0]        tsrc;
    logic              ssrc;
    logic [31:0]       pre_len;
    logic [31:0]       post_len;
    logic [31:0]       used;
    logic [31:0]       pre_cnt;
    logic [31:0]       cur_pre;
    logic [31:0]       btw_cnt;
    logic [31:0]       post_cnt;
    logic [31:0]       last_pre;
    logic [31:0]       last_btw;
    logic [31:0]       last_post;
    logic [31:0]       sweeps;
    logic [31:0]       ts;
    logic              susp;
    logic              exh;
    logic              rec_valid;
    logic [DATA_W-1:0] rec_data;
    logic [1:0]        rec_seg;
    logic              marker;
    logic              done;
    logic              log_valid;
    logic [31:0]       log_time;
    logic [1:0]        log_src;
  } rec_state_t;
  rec_state_t  q;
  rec_state_t  n;
  logic [31:0] free;
  logic [31:0] need;
  logic [31:0] pre_inc;
  logic        dec;
  logic        emit;
  logic        count;
  logic        end_now;
  logic        wr;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  trig_if tif ();
  assign tif.tsrc = q.tsrc;
  assign tif.ssrc = q.ssrc;
  trig_select u_sel (
    .pclk         (pclk),
    .presetn      (presetn),
    .ext_trig     (ext_trig),
    .analog_trig  (analog_trig),
    .digital_trig (digital_trig),
    .formula_trig (formula_trig),
    .formula_stop (formula_stop),
    .tif          (tif)
  );
  always_comb begin
    n            = q;
    n.rec_valid  = 1'b0;
    n.marker     = 1'b0;
    n.done       = 1'b0;
    n.log_valid  = 1'b0;
    n.ts         = q.ts + 32'h1;
    emit         = 1'b0;
    count        = 1'b0;
    end_now      = 1'b0;
    dec          = drain_ack && (q.used != 32'h0);
    free         = 32'(MEM_DEPTH) - q.used;
    need         = q.pre_len + q.post_len
                   + ((q.mode == sweep_pkg::MODE_STOP) ? 32'(BTW_RESERVE) : 32'h0);
    // Pre count saturates at the set length
    pre_inc      = q.pre_cnt + {31'h0, sample_valid && (q.pre_cnt < q.pre_len)};
    // One wait state so read data leaves a flip-flop
    wr       = psel && penable && q.pready && pwrite;
    n.pready = psel && penable && !q.pready;
    if (n.pready) begin
      n.prdata  = 32'h0;
      n.pslverr = 1'b0;
      case (paddr)
        sweep_pkg::ADDR_CTRL: begin
          n.prdata[sweep_pkg::CTRL_EN_BIT]        = q.en;
          n.prdata[sweep_pkg::CTRL_STREAM_BIT]    = q.stream;
          n.prdata[sweep_pkg::CTRL_MODE_LSB +: 2] = q.mode;
          n.prdata[sweep_pkg::CTRL_TSRC_LSB +: 2] = q.tsrc;
          n.prdata[sweep_pkg::CTRL_SSRC_BIT]      = q.ssrc;
        end
        sweep_pkg::ADDR_PRE_LEN:  n.prdata = q.pre_len;
        sweep_pkg::ADDR_POST_LEN: n.prdata = q.post_len;
        sweep_pkg::ADDR_STATUS: begin
          n.prdata[sweep_pkg::STAT_SUSP_BIT]       = q.susp;
          n.prdata[sweep_pkg::STAT_EXH_BIT]        = q.exh;
          n.prdata[sweep_pkg::STAT_PHASE_LSB +: 2] = q.phase;
        end
        sweep_pkg::ADDR_USED:     n.prdata = q.used;
        sweep_pkg::ADDR_LAST_PRE: n.prdata = q.last_pre;
        sweep_pkg::ADDR_LAST_BTW: n.prdata = q.last_btw;
        sweep_pkg::ADDR_LAST_PST: n.prdata = q.last_post;
        sweep_pkg::ADDR_SWEEPS:   n.prdata = q.sweeps;
        default:                  n.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        sweep_pkg::ADDR_CTRL: begin
          n.en     = pwdata[sweep_pkg::CTRL_EN_BIT];
          n.stream = pwdata[sweep_pkg::CTRL_STREAM_BIT];
          n.mode   = pwdata[sweep_pkg::CTRL_MODE_LSB +: 2];
          n.tsrc   = pwdata[sweep_pkg::CTRL_TSRC_LSB +: 2];
          n.ssrc   = pwdata[sweep_pkg::CTRL_SSRC_BIT];
        end
        sweep_pkg::ADDR_PRE_LEN:  n.pre_len  = pwdata;
        sweep_pkg::ADDR_POST_LEN: n.post_len = pwdata;
        sweep_pkg::ADDR_STATUS:   n.exh      = q.exh && !pwdata[sweep_pkg::STAT_EXH_BIT];
        default: ;
      endcase
    end
    // Drain runs in every mode, including while suspended
    n.used = q.used - {31'h0, dec};
    if (!q.en) begin
      n.phase    = PH_IDLE;
      n.susp     = 1'b0;
      n.pre_cnt  = 32'h0;
      n.btw_cnt  = 32'h0;
      n.post_cnt = 32'h0;
    end else if (q.stream) begin
      n.rec_seg = sweep_pkg::SEG_STREAM;
      if (q.susp) begin
        if ((q.used == 32'h0) && peer_fifo_empty) begin
          n.susp   = 1'b0;
          n.marker = 1'b1;
        end
      end else if (sample_valid) begin
        emit  = 1'b1;
        count = 1'b1;
      end
    end else begin
      case (q.phase)
        PH_IDLE: begin
          n.phase   = PH_PRE;
          n.pre_cnt = 32'h0;
        end
        PH_PRE: begin
          if (sample_valid) begin
            emit      = 1'b1;
            n.rec_seg = sweep_pkg::SEG_PRE;
            n.pre_cnt = pre_inc;
          end
          if (tif.trig) begin
            n.log_valid = 1'b1;
            if (free >= need) begin
              // Pre segment is whatever was gathered so far
              n.cur_pre  = pre_inc;
              n.used     = n.used + pre_inc;
              n.btw_cnt  = 32'h0;
              n.post_cnt = 32'h0;
              if (q.mode == sweep_pkg::MODE_STOP) begin
                n.phase = PH_BTW;
              end else if (q.post_len == 32'h0) begin
                end_now = 1'b1;
              end else begin
                n.phase = PH_POST;
              end
            end else begin
              n.exh = 1'b1;
            end
          end
        end
        PH_BTW: begin
          // Triggers are not looked at here
          if (tif.stop) begin
            if (q.post_len == 32'h0) begin
              end_now = 1'b1;
            end else begin
              n.phase = PH_POST;
            end
          end else if (q.used >= 32'(MEM_DEPTH)) begin
            end_now = 1'b1;
            n.exh   = 1'b1;
          end else if (sample_valid) begin
            emit      = 1'b1;
            count     = 1'b1;
            n.rec_seg = sweep_pkg::SEG_BTW;
            n.btw_cnt = q.btw_cnt + 32'h1;
          end
        end
        PH_POST: begin
          // Stop-triggers never matter here
          if ((q.mode == sweep_pkg::MODE_EVERY) && tif.trig) begin
            n.log_valid = 1'b1;
            if (q.post_len <= free) begin
              n.btw_cnt  = q.btw_cnt + q.post_cnt;
              n.post_cnt = 32'h0;
            end else begin
              end_now = 1'b1;
              n.exh   = 1'b1;
            end
          end else if (sample_valid) begin
            emit       = 1'b1;
            count      = 1'b1;
            n.rec_seg  = sweep_pkg::SEG_POST;
            n.post_cnt = q.post_cnt + 32'h1;
            if (n.post_cnt >= q.post_len) begin
              end_now = 1'b1;
            end
          end
        end
        default: n.phase = PH_IDLE;
      endcase
    end
    if (emit) begin
      n.rec_valid = 1'b1;
      n.rec_data  = sample_data;
    end
    if (count) begin
      n.used = n.used + 32'h1;
    end
    if (q.en && q.stream && !q.susp && (n.used >= 32'(MEM_DEPTH))) begin
      n.susp = 1'b1;
    end
    if (n.log_valid) begin
      n.log_time = q.ts;
      n.log_src  = q.tsrc;
    end
    // Closing a sweep commits all segments gathered so far
    if (end_now) begin
      n.last_pre  = n.cur_pre;
      n.last_btw  = n.btw_cnt;
      n.last_post = n.post_cnt;
      n.sweeps    = q.sweeps + 32'h1;
      n.done      = 1'b1;
      n.phase     = PH_PRE;
      n.pre_cnt   = 32'h0;
    end
  end
  // All-zero reset leaves the phase idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.mode     <= sweep_pkg::MODE_RST;
      q.pre_len  <= sweep_pkg::PRE_LEN_RST;
      q.post_len <= sweep_pkg::POST_LEN_RST;
    end else begin
      q <= n;
    end
  end
  assign pready        = q.pready;
  assign prdata        = q.prdata;
  assign pslverr       = q.pslverr;
  assign rec_valid     = q.rec_valid;
  assign rec_data      = q.rec_data;
  assign rec_seg       = q.rec_seg;
  assign rec_marker    = q.marker;
  assign sweep_done    = q.done;
  assign log_valid     = q.log_valid;
  assign log_time      = q.log_time;
  assign log_src       = q.log_src;
  assign suspended     = q.susp;
  assign mem_exhausted = q.exh;
  susp_drain_a: assert property (
    q.en && q.stream && q.susp && drain_ack && (q.used != 32'h0)
    |=> (q.used == $past(q.used) - 32'h1) && !rec_valid)
    else $error("suspended FIFO did not drain by one");
  auto_resume_a: assert property (
    q.en && q.stream && q.susp && (q.used == 32'h0) && peer_fifo_empty
    |=> !suspended && rec_marker)
    else $error("recording did not resume on empty FIFO");
  gap_marker_a: assert property (
    rec_marker |-> $past(q.susp) && !q.susp)
    else $error("marker without a suspension");
  pre_short_a: assert property (
    q.en && !q.stream && (q.phase == PH_PRE) && tif.trig && (free >= need)
    |=> (q.cur_pre <= $past(q.pre_len)) && (q.cur_pre <= $past(q.pre_cnt) + 32'h1))
    else $error("pre segment longer than set length");
  first_ignore_a: assert property (
    q.en && !q.stream && (q.mode == sweep_pkg::MODE_FIRST)
    && (q.phase == PH_POST) && tif.trig
    |=> (q.btw_cnt == 32'h0) && (q.post_cnt >= $past(q.post_cnt)))
    else $error("first mode reacted to retrigger");
  every_restart_a: assert property (
    q.en && !q.stream && (q.mode == sweep_pkg::MODE_EVERY)
    && (q.phase == PH_POST) && tif.trig && (q.post_len <= free)
    |=> (q.post_cnt == 32'h0)
    && (q.btw_cnt == $past(q.btw_cnt) + $past(q.post_cnt)))
    else $error("retrigger did not restart post count");
  stop_ignore_a: assert property (
    q.en && !q.stream && (q.mode == sweep_pkg::MODE_STOP)
    && (q.phase == PH_PRE) && tif.stop && !tif.trig
    |=> (q.phase == PH_PRE) && !sweep_done)
    else $error("stop-trigger acted during pre phase");
  nofit_refuse_a: assert property (
    q.en && !q.stream && (q.phase == PH_PRE) && tif.trig && (free < need)
    |=> (q.phase == PH_PRE) && log_valid && mem_exhausted
    && (q.used <= $past(q.used)))
    else $error("sweep started without room");
  full_end_a: assert property (
    q.en && !q.stream && (q.phase == PH_BTW) && !tif.stop
    && (q.used >= 32'(MEM_DEPTH))
    |=> sweep_done && (q.phase == PH_PRE))
    else $error("full memory did not end the sweep");
endmodule
`default_nettype wire

// [bench/drive_path_model.sv]
// Storage drive transfer path model: drains card memory, reports other cards
`timescale 1ns/1ps
`default_nettype none
module drive_path_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [7:0] words,
  input  wire logic [3:0] gap,
  input  wire logic [7:0] lag,
  output logic            drain_ack,
  output logic            peer_fifo_empty,
  output logic            done
);
  logic [7:0] taken;
  logic [7:0] wait_cnt;

  always @(posedge pclk) begin
    if (!presetn || !go) begin
      taken <= 8'h00;
      wait_cnt <= 8'h00;
      drain_ack <= 1'b0;
      peer_fifo_empty <= 1'b1;
      done <= 1'b0;
    end else begin
      drain_ack <= 1'b0;
      wait_cnt <= wait_cnt + 8'h01;
      if (taken != words) begin
        // Other cards still hold data while this one drains
        peer_fifo_empty <= 1'b0;
        if (wait_cnt[3:0] >= gap) begin
          drain_ack <= 1'b1;
          taken <= taken + 8'h01;
          wait_cnt <= 8'h00;
        end
      end else begin
        done <= 1'b1;
        // Peers lag behind, so resume must wait for them too
        if (wait_cnt >= lag) begin
          peer_fifo_empty <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the sweep recorder with a drive path model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); \
  end \
end
module testbench;
  localparam int MEM = 64;
  localparam int RSV = 16;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  tin = 5'h00;
  logic        sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0;
  logic        go = 1'b0;
  logic [31:0] prdata;
  logic [31:0] log_time;
  logic [15:0] rec_data;
  logic [1:0]  rec_seg;
  logic [1:0]  log_src;
  logic        pready, pslverr, rec_valid, rec_marker, sweep_done, log_valid;
  logic        suspended, mem_exhausted, drain_ack, peer_fifo_empty, pdone;
  logic [33:0] sq[$];
  logic [33:0] lq[$];
  logic [33:0] rq[$];
  int          errors, cmp_count, seed, dones, marks, cyc;

  always #25 pclk = ~pclk;

  sweep_recorder #(.DATA_W(16), .MEM_DEPTH(MEM), .BTW_RESERVE(RSV)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_trig(tin[0]), .analog_trig(tin[1]),
    .digital_trig(tin[2]), .formula_trig(tin[3]), .formula_stop(tin[4]),
    .sample_valid(sample_valid), .sample_data(sample_data), .drain_ack(drain_ack),
    .peer_fifo_empty(peer_fifo_empty), .rec_valid(rec_valid), .rec_data(rec_data),
    .rec_seg(rec_seg), .rec_marker(rec_marker), .sweep_done(sweep_done),
    .log_valid(log_valid), .log_time(log_time), .log_src(log_src), .suspended(suspended),
    .mem_exhausted(mem_exhausted));

  drive_path_model drv (.pclk(pclk), .presetn(presetn), .go(go), .words(8'h40),
    .gap(4'h2), .lag(8'h14), .drain_ack(drain_ack), .peer_fifo_empty(peer_fifo_empty),
    .done(pdone));

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic take(ref logic [33:0] q[$], input logic [33:0] got);
    logic [33:0] e;
    if (q.size() == 0) begin
      errors++;
      $display("[ERR] %0t unexpected output %h", $time, got);
    end else begin
      e = q.pop_front();
      `CHK(got, e)
    end
  endtask

  // Oldest note first: outputs must come in the order they were caused
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (rec_valid === 1'b1) take(sq, {16'h0, rec_seg, rec_data});
      if (log_valid === 1'b1) begin
        take(lq, {32'h0, log_src});
        // Stamp is the cycle count since release at the acting edge
        `CHK(log_time, cyc - 1)
      end
      if (pready === 1'b1 && pwrite === 1'b0) take(rq, {pslverr, 1'b0, prdata});
      if (sweep_done === 1'b1) dones++;
      if (rec_marker === 1'b1) marks++;
      cyc++;
    end else begin
      cyc = 0;
    end
  end

  task automatic waitv(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 2000) begin
      errors++;
      $display("[ERR] %0t wait limit reached", $time);
      give_verdict();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    waitv(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge: no double drive of psel, and the enable is seen before samples
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic err);
    rq.push_back({err, 1'b0, x});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    dones = 0;
    marks = 0;
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] t, input logic s,
                     input logic st, input int pre, input int post);
    apb(1'b1, sweep_pkg::ADDR_PRE_LEN, 32'(pre));
    apb(1'b1, sweep_pkg::ADDR_POST_LEN, 32'(post));
    apb(1'b1, sweep_pkg::ADDR_CTRL, {25'h0, s, t, m, st, 1'b1});
  endtask

  task automatic smp(input int n, input logic [1:0] seg, input logic keep);
    logic [15:0] d;
    repeat (n) begin
      d = 16'($random(seed));
      sample_valid <= 1'b1;
      sample_data <= d;
      if (keep) sq.push_back({16'h0, seg, d});
      @(posedge pclk);
    end
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Samples are held off around a trigger so segment edges are unambiguous
  task automatic pulse(input int i, input logic [1:0] src, input logic logged);
    if (logged) lq.push_back({32'h0, src});
    tin[i] <= 1'b1;
    @(posedge pclk);
    tin[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic last(input int p, input int b, input int s);
    rd(sweep_pkg::ADDR_LAST_PRE, 32'(p), 1'b0);
    rd(sweep_pkg::ADDR_LAST_BTW, 32'(b), 1'b0);
    rd(sweep_pkg::ADDR_LAST_PST, 32'(s), 1'b0);
    rd(sweep_pkg::ADDR_SWEEPS, 32'h1, 1'b0);
    `CHK(dones, 1)
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    $display("[ERR] %0t run limit reached", $time);
    give_verdict();
  end

  initial begin
    seed = 32'h93abbbf6;
    errors = 0;
    cmp_count = 0;
    do_reset();
    rd(sweep_pkg::ADDR_CTRL, 32'h0, 1'b0);
    rd(sweep_pkg::ADDR_PRE_LEN, sweep_pkg::PRE_LEN_RST, 1'b0);
    rd(sweep_pkg::ADDR_POST_LEN, sweep_pkg::POST_LEN_RST, 1'b0);
    rd(sweep_pkg::ADDR_STATUS, 32'h0, 1'b0);
    rd(sweep_pkg::ADDR_USED, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    apb(1'b1, 8'h24, 32'hffff_ffff);
    apb(1'b1, sweep_pkg::ADDR_PRE_LEN, 32'h5);
    rd(sweep_pkg::ADDR_PRE_LEN, 32'h5, 1'b0);
    for (int t = 0; t < 4; t++) begin
      do_reset();
      cfg(sweep_pkg::MODE_FIRST, 2'(t), 1'b0, 1'b0, 8, 4);
      smp(3, sweep_pkg::SEG_PRE, 1'b1);
      pulse((t + 1) % 4, 2'(t), 1'b0);
      pulse(t, 2'(t), 1'b1);
      smp(2, sweep_pkg::SEG_POST, 1'b1);
      pulse(t, 2'(t), 1'b0);
      smp(2, sweep_pkg::SEG_POST, 1'b1);
      last(3, 0, 4);
      rd(sweep_pkg::ADDR_USED, 32'h7, 1'b0);
    end
    do_reset();
    cfg(sweep_pkg::MODE_EVERY, sweep_pkg::TSRC_DIGITAL, 1'b0, 1'b0, 2, 4);
    smp(2, sweep_pkg::SEG_PRE, 1'b1);
    pulse(2, sweep_pkg::TSRC_DIGITAL, 1'b1);
    smp(2, sweep_pkg::SEG_POST, 1'b1);
    pulse(2, sweep_pkg::TSRC_DIGITAL, 1'b1);
    smp(4, sweep_pkg::SEG_POST, 1'b1);
    last(2, 2, 4);
    do_reset();
    cfg(sweep_pkg::MODE_EVERY, sweep_pkg::TSRC_EXT, 1'b0, 1'b0, 2, 40);
    smp(2, sweep_pkg::SEG_PRE, 1'b1);
    pulse(0, sweep_pkg::TSRC_EXT, 1'b1);
    smp(30, sweep_pkg::SEG_POST, 1'b1);
    pulse(0, sweep_pkg::TSRC_EXT, 1'b1);
    last(2, 0, 30);
    `CHK(mem_exhausted, 1'b1)
    for (int s = 0; s < 2; s++) begin
      do_reset();
      cfg(sweep_pkg::MODE_STOP, sweep_pkg::TSRC_ANALOG, 1'(s), 1'b0, 2, 3);
      smp(2, sweep_pkg::SEG_PRE, 1'b1);
      pulse(s * 4, 2'h0, 1'b0);
      pulse(1, sweep_pkg::TSRC_ANALOG, 1'b1);
      smp(3, sweep_pkg::SEG_BTW, 1'b1);
      pulse(1, sweep_pkg::TSRC_ANALOG, 1'b0);
      pulse(s * 4, 2'h0, 1'b0);
      smp(1, sweep_pkg::SEG_POST, 1'b1);
      pulse(s * 4, 2'h0, 1'b0);
      pulse(1, sweep_pkg::TSRC_ANALOG, 1'b0);
      smp(2, sweep_pkg::SEG_POST, 1'b1);
      last(2, 3, 3);
    end
    do_reset();
    cfg(sweep_pkg::MODE_STOP, sweep_pkg::TSRC_EXT, 1'b1, 1'b0, 2, 4);
    smp(2, sweep_pkg::SEG_PRE, 1'b1);
    pulse(0, sweep_pkg::TSRC_EXT, 1'b1);
    smp(MEM - 2, sweep_pkg::SEG_BTW, 1'b1);
    last(2, MEM - 2, 0);
    `CHK(mem_exhausted, 1'b1)
    for (int k = 0; k < 2; k++) begin
      do_reset();
      cfg(k ? sweep_pkg::MODE_STOP : sweep_pkg::MODE_FIRST, sweep_pkg::TSRC_FORMULA,
          1'b1, 1'b0, k ? 2 : 34, MEM - (k ? 2 + RSV : 34) + 1);
      smp(3, sweep_pkg::SEG_PRE, 1'b1);
      pulse(3, sweep_pkg::TSRC_FORMULA, 1'b1);
      smp(2, sweep_pkg::SEG_PRE, 1'b1);
      `CHK(mem_exhausted, 1'b1)
      rd(sweep_pkg::ADDR_USED, 32'h0, 1'b0);
      apb(1'b1, sweep_pkg::ADDR_STATUS, 32'h2);
      @(posedge pclk);
      `CHK(mem_exhausted, 1'b0)
    end
    do_reset();
    cfg(sweep_pkg::MODE_FIRST, sweep_pkg::TSRC_EXT, 1'b0, 1'b1, 0, 0);
    smp(MEM, sweep_pkg::SEG_STREAM, 1'b1);
    `CHK(suspended, 1'b1)
    smp(4, sweep_pkg::SEG_STREAM, 1'b0);
    go <= 1'b1;
    waitv(pdone, 1'b1);
    @(posedge pclk);
    `CHK(suspended, 1'b1)
    waitv(suspended, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK(marks, 1)
    go <= 1'b0;
    rd(sweep_pkg::ADDR_USED, 32'h0, 1'b0);
    smp(3, sweep_pkg::SEG_STREAM, 1'b1);
    `CHK(sq.size() + lq.size() + rq.size(), 0)
    give_verdict();
  end
endmodule
`default_nettype wire
